/* verilog/dmm_pkg.sv */
// Package for the data memory address map block.
// Assumes one 10 MHz clock shared with the CPU core that issues accesses.
package dmm_pkg;
   localparam int unsigned DMM_IRAM_DEPTH = 256;
   localparam int unsigned DMM_ON_CHIP_EXTERNAL_RAM_DEPTH = 256;
   localparam logic [7:0] DMM_UPPER_BASE = 8'h80;
   localparam logic [7:0] DMM_BANK_TOP = 8'h1F;
   localparam logic [7:0] DMM_BIT_BASE = 8'h20;
   localparam logic [7:0] DMM_BIT_TOP = 8'h2F;
   localparam logic [7:0] DMM_SP_RESET = 8'h07;
   localparam logic [7:0] DMM_PSW_RESET = 8'h00;
   localparam int unsigned DMM_BANK_SEL_LOW_POS = 3;
   localparam int unsigned DMM_BANK_SEL_HIGH_POS = 4;
   localparam logic [7:0] DMM_SFR_STACK_PTR = 8'h81;
   localparam logic [7:0] DMM_SFR_PSW = 8'hD0;
   localparam logic [7:0] DMM_UID_BASE = 8'hFC;
   // Unique identifier value is arbitrary
   localparam logic [31:0] DMM_UID_VALUE = 32'h1234_5678;

   typedef enum logic [2:0] {
      DMM_OP_DIRECT,
      DMM_OP_INDIRECT,
      DMM_OP_BIT,
      DMM_OP_PUSH,
      DMM_OP_POP,
      DMM_OP_XDATA16,
      DMM_OP_XDATA8
   } dmm_op_t;

   typedef struct packed {
      logic valid;
      logic write;
      dmm_op_t op;
      logic indirect_sel;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dmm_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic bit_value;
      logic sfr_hit;
   } dmm_rsp_t;
endpackage : dmm_pkg

/* verilog/dmm_data_map.sv */
// Data memory map: internal RAM, banks, bit area, stack and on-chip external RAM.
// Assumes the CPU core holds one request per cycle; answers one cycle later.
`timescale 1ns/10ps

// Operation
// [R01] Upper 128 RAM bytes reachable only indirectly, separate from special space.
// [R02] Above 0x7F, direct goes to special space, indirect to upper RAM.
// [R03] Bytes 0x00 to 0x1F form four banks of eight registers.
// [R04] One bank active at a time, chosen by two status word bits.
// [R05] Indirect address taken from register zero or one of active bank.
// [R06] Bytes 0x20 to 0x2F also form 128 addressable bits.
// [R07] Bit address 8k plus n maps to bit n of byte 0x20 plus k.
// [R08] Bit or byte access chosen by operation type, not address.
// [R09] Push writes at pointer plus one, then pointer increments.
// [R10] Stack pointer resets to 0x07, first push lands at 0x08.
// [R11] Stack may sit anywhere in 256 bytes and use all of it.
// [R12] 256 bytes external RAM via 16-bit pointer or 8-bit indirect.
// [R13] Upper eight bits of 16-bit external address ignored, mirroring.
// [R14] External moves go to on-chip external RAM by default.
// [R15] Small-RAM variant holds 32-bit identifier in top internal bytes.
// [R16] Large-RAM variant holds 32-bit identifier in top external bytes.
// [R17] Bank number n places active bank at base 8 times n.
// [R18] Stack pointer wraps modulo 256.
module dmm_data_map
   import dmm_pkg::*;
#(
   parameter bit LARGE_RAM = 1'b1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire dmm_req_t req,
   input wire logic [7:0] sfr_rdata,
   output dmm_rsp_t rsp,
   output logic sfr_we,
   output logic sfr_re,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic [7:0] stack_top_pointer,
   output logic [7:0] program_status_word
);

   logic [7:0] iram [DMM_IRAM_DEPTH];
   logic [7:0] on_chip_external_ram [DMM_ON_CHIP_EXTERNAL_RAM_DEPTH];
   logic op_direct;
   logic op_indirect;
   logic op_bit;
   logic op_push;
   logic op_pop;
   logic op_xdata;
   logic [1:0] bank_num;
   logic [7:0] bank_base;
   logic [7:0] ptr_addr;
   logic [7:0] ind_addr;
   logic [7:0] bit_byte;
   logic [2:0] bit_pos;
   logic [7:0] sfr_byte;
   logic [7:0] x_addr;
   logic [7:0] next_sp;
   logic [7:0] next_psw;
   logic is_sfr;
   logic [7:0] iaddr;
   logic iram_we;
   logic on_chip_external_ram_we;
   logic sfr_wr;
   logic sp_wr;
   logic psw_wr;
   logic psw_bit_wr;
   logic iram_uid;
   logic on_chip_external_ram_uid;
   logic [7:0] wr_merge;
   logic [7:0] rd_byte;
   logic [1:0] uid_i;
   logic [1:0] uid_x;

   // One flag per operation, both external moves sharing op_xdata, so the decoders below stay readable
   always_comb begin
      op_direct = 1'b0;
      op_indirect = 1'b0;
      op_bit = 1'b0;
      op_push = 1'b0;
      op_pop = 1'b0;
      op_xdata = 1'b0;
      case (req.op)
         DMM_OP_DIRECT: begin
            op_direct = 1'b1;
         end
         DMM_OP_INDIRECT: begin
            op_indirect = 1'b1;
         end
         DMM_OP_BIT: begin
            op_bit = 1'b1; // [R08]
         end
         DMM_OP_PUSH: begin
            op_push = 1'b1;
         end
         DMM_OP_POP: begin
            op_pop = 1'b1;
         end
         DMM_OP_XDATA16, DMM_OP_XDATA8: begin
            op_xdata = 1'b1; // [R14]
         end
         default: begin
            op_xdata = 1'b0;
         end
      endcase
   end

   // Bank, pointer and bit addressing
   assign bank_num = {program_status_word[DMM_BANK_SEL_HIGH_POS],
      program_status_word[DMM_BANK_SEL_LOW_POS]}; // [R04]
   assign bank_base = {3'h0, bank_num, 3'h0}; // [R17] [R03]
   assign ptr_addr = bank_base | {7'h00, req.indirect_sel}; // [R05]
   assign ind_addr = iram[ptr_addr]; // [R05]
   assign bit_byte = DMM_BIT_BASE + {4'h0, req.addr[6:3]}; // [R06] [R07]
   assign bit_pos = req.addr[2:0]; // [R07]
   assign sfr_byte = op_bit ? {req.addr[7:3], 3'h0} : req.addr[7:0];
   assign x_addr = (req.op == DMM_OP_XDATA16) ? req.addr[7:0] : ind_addr; // [R13] [R12]

   // Direct above 0x7F is special space; bit ops use 0x80 up likewise
   always_comb begin
      is_sfr = 1'b0;
      iaddr = 8'h00;
      case (req.op)
         DMM_OP_DIRECT: begin
            is_sfr = req.addr[7:0] >= DMM_UPPER_BASE; // [R02] [R01]
            iaddr = req.addr[7:0];
         end
         DMM_OP_INDIRECT: begin
            iaddr = ind_addr; // [R02] [R01]
         end
         DMM_OP_BIT: begin
            is_sfr = req.addr[7]; // [R08]
            iaddr = bit_byte; // [R06] [R07]
         end
         DMM_OP_PUSH: begin
            iaddr = stack_top_pointer + 8'h01; // [R09] [R11] [R18]
         end
         DMM_OP_POP: begin
            iaddr = stack_top_pointer; // [R11]
         end
         default: begin
            iaddr = 8'h00;
         end
      endcase
   end

   // Write decode for the internal stores and the special space
   assign iram_uid = !LARGE_RAM && iaddr >= DMM_UID_BASE; // [R15]
   assign on_chip_external_ram_uid = LARGE_RAM && x_addr >= DMM_UID_BASE; // [R16]
   always_comb begin
      iram_we = 1'b0;
      on_chip_external_ram_we = 1'b0;
      sfr_wr = 1'b0;
      sp_wr = 1'b0;
      psw_wr = 1'b0;
      psw_bit_wr = 1'b0;
      if (req.valid && op_push) begin
         iram_we = !iram_uid; // [R09] [R15]
      end else if (req.valid && req.write && op_xdata) begin
         on_chip_external_ram_we = LARGE_RAM && !on_chip_external_ram_uid; // [R14] [R12] [R16]
      end else if (req.valid && req.write && is_sfr) begin
         sfr_wr = op_direct;
         sp_wr = op_direct && sfr_byte == DMM_SFR_STACK_PTR; // [R11]
         psw_wr = op_direct && sfr_byte == DMM_SFR_PSW; // [R04]
         psw_bit_wr = op_bit && sfr_byte == DMM_SFR_PSW; // [R04]
      end else if (req.valid && req.write && (op_direct || op_indirect || op_bit)) begin
         iram_we = !iram_uid; // [R01] [R03]
      end
   end

   // Bit writes replace one bit of the addressed byte, byte writes all eight
   for (genvar gi = 0; gi < 8; gi++) begin : g_merge
      assign wr_merge[gi] = !op_bit ? req.wdata[gi] :
         (bit_pos == 3'(gi)) ? req.wdata[0] : iram[iaddr][gi]; // [R07] [R08]
   end

   // Stack pointer next value
   always_comb begin
      next_sp = stack_top_pointer;
      if (req.valid && op_push) begin
         next_sp = stack_top_pointer + 8'h01; // [R09] [R18]
      end else if (req.valid && op_pop) begin
         next_sp = stack_top_pointer - 8'h01; // [R18]
      end else if (sp_wr) begin
         next_sp = req.wdata; // [R11]
      end
   end

   // Status word next value, whole byte or one bit
   always_comb begin
      next_psw = program_status_word;
      if (psw_wr) begin
         next_psw = req.wdata; // [R04]
      end else if (psw_bit_wr) begin
         next_psw[bit_pos] = req.wdata[0]; // [R04] [R17]
      end
   end

   // Stack pointer
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stack_top_pointer <= DMM_SP_RESET; // [R10]
      end else begin
         stack_top_pointer <= next_sp;
      end
   end

   // Status word holding the bank select bits
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         program_status_word <= DMM_PSW_RESET;
      end else begin
         program_status_word <= next_psw; // [R04]
      end
   end

   // Internal RAM, not reset
   always_ff @(posedge ref_clk) begin
      if (iram_we) begin
         iram[iaddr] <= wr_merge; // [R03] [R06]
      end
   end

   // On-chip external RAM, not reset
   always_ff @(posedge ref_clk) begin
      if (on_chip_external_ram_we) begin
         on_chip_external_ram[x_addr] <= req.wdata; // [R13]
      end
   end

   // Special space write strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_we <= 1'b0;
      end else begin
         sfr_we <= sfr_wr; // [R02]
      end
   end

   // Special space read strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_re <= 1'b0;
      end else begin
         sfr_re <= req.valid && is_sfr && !req.write; // [R02]
      end
   end

   // Special space address, byte aligned for bit operations
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_addr <= 8'h00;
      end else begin
         sfr_addr <= sfr_byte; // [R02]
      end
   end

   // Special space write data
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_wdata <= 8'h00;
      end else begin
         sfr_wdata <= req.wdata;
      end
   end

   // Read data, chosen from the state before this cycle's write
   assign uid_i = 2'(iaddr - DMM_UID_BASE);
   assign uid_x = 2'(x_addr - DMM_UID_BASE);
   always_comb begin
      rd_byte = 8'h00;
      if (op_xdata) begin
         if (!LARGE_RAM) begin
            rd_byte = 8'h00;
         end else if (on_chip_external_ram_uid) begin
            rd_byte = DMM_UID_VALUE[8 * uid_x +: 8]; // [R16]
         end else begin
            rd_byte = on_chip_external_ram[x_addr]; // [R14]
         end
      end else if (is_sfr) begin
         if (sfr_byte == DMM_SFR_STACK_PTR) begin
            rd_byte = stack_top_pointer; // [R11]
         end else if (sfr_byte == DMM_SFR_PSW) begin
            rd_byte = program_status_word; // [R04]
         end else begin
            rd_byte = sfr_rdata; // [R02]
         end
      end else if (iram_uid) begin
         rd_byte = DMM_UID_VALUE[8 * uid_i +: 8]; // [R15]
      end else begin
         rd_byte = iram[iaddr]; // [R01]
      end
   end

   // Response, one cycle after the request
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.valid;
         rsp.rdata <= rd_byte;
         rsp.bit_value <= rd_byte[bit_pos]; // [R08]
         rsp.sfr_hit <= req.valid && is_sfr;
      end
   end

endmodule : dmm_data_map

/* testbench/dmm_cpu_model.sv */
// Far-side model: special space answering the core's direct reads.
// Assumes reads are combinational in the cycle of the request.
`timescale 1ns/10ps
module dmm_cpu_model
   import dmm_pkg::*;
(
   input wire dmm_req_t req,
   output logic [7:0] sfr_rdata
);
   // Inverse of address, so a stale value never matches
   assign sfr_rdata = ~req.addr[7:0];
endmodule : dmm_cpu_model

/* testbench/dmm_data_map_asserts.sv */
// Port checks on the data memory map.
// Assumes it is bound to dmm_data_map from the bench top file.
`timescale 1ns/10ps
module dmm_data_map_asserts
   import dmm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire dmm_req_t req,
   input wire logic [7:0] sfr_rdata,
   input wire dmm_rsp_t rsp,
   input wire logic sfr_we,
   input wire logic sfr_re,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] stack_top_pointer,
   input wire logic [7:0] program_status_word
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic v, dsf, nsf;
   logic [7:0] sp;
   assign v = req.valid;
   assign sp = stack_top_pointer;
   assign dsf = v && req.op == DMM_OP_DIRECT && req.addr[7] && req.addr[7:0] != DMM_SFR_STACK_PTR
      && req.addr[7:0] != DMM_SFR_PSW;
   assign nsf = !sfr_we && !sfr_re;
   property p_answer; v |=> rsp.valid; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_push; v && req.op == DMM_OP_PUSH |=> sp == $past(sp) + 8'h01; endproperty
   a_push: assert property (p_push) else $error("push pointer");
   property p_pop; v && req.op == DMM_OP_POP |=> sp == $past(sp) - 8'h01; endproperty
   a_pop: assert property (p_pop) else $error("pop pointer");
   property p_hold; !v |=> $stable(sp) && $stable(program_status_word); endproperty
   a_hold: assert property (p_hold) else $error("idle change");
   property p_sfr_wr; dsf && req.write |=> sfr_we && sfr_addr == $past(req.addr[7:0]); endproperty
   a_sfr_wr: assert property (p_sfr_wr) else $error("special write");
   property p_sfr_rd; dsf && !req.write |=> sfr_re && rsp.rdata == $past(sfr_rdata); endproperty
   a_sfr_rd: assert property (p_sfr_rd) else $error("special read");
   property p_ind; v && req.op == DMM_OP_INDIRECT |=> nsf; endproperty
   a_ind: assert property (p_ind) else $error("indirect strobe");
   property p_low; v && req.op == DMM_OP_DIRECT && !req.addr[7] |=> nsf; endproperty
   a_low: assert property (p_low) else $error("low strobe");
   c_push: cover property (v && req.op == DMM_OP_PUSH);
   c_bit: cover property (v && req.op == DMM_OP_BIT);
   c_on_chip_external_ram: cover property (v && req.op == DMM_OP_XDATA8);
endmodule : dmm_data_map_asserts

/* testbench/tb.sv */
// Directed bench for the data memory map, large-RAM variant with the small-RAM variant alongside.
// Assumes package, design, model and checker compile first.
`timescale 1ns/10ps
module tb;
   import dmm_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   dmm_req_t req = '0;
   dmm_rsp_t rsp;
   logic sfr_we, sfr_re;
   logic [7:0] sfr_rdata, sfr_addr, sfr_wdata, stack_top_pointer, program_status_word;
   int n_errors = 0;
   int comparisons = 0;
   initial forever #50 ref_clk = ~ref_clk;
   dmm_rsp_t rsp_small;
   dmm_data_map #(.LARGE_RAM(1'b1)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .sfr_rdata(sfr_rdata),
      .rsp(rsp), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .stack_top_pointer(stack_top_pointer), .program_status_word(program_status_word));
   // Small-RAM variant sees the same traffic; only its answers are judged
   dmm_data_map #(.LARGE_RAM(1'b0)) u_dut_small (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
      .sfr_rdata(sfr_rdata), .rsp(rsp_small), .sfr_we(), .sfr_re(), .sfr_addr(), .sfr_wdata(),
      .stack_top_pointer(), .program_status_word());
   dmm_cpu_model u_cpu (.req(req), .sfr_rdata(sfr_rdata));
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task acc(input dmm_op_t op, input logic wr, input logic sel, input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{1'b1, wr, op, sel, a, d};
      @(posedge ref_clk);
      req.valid <= 1'b0;
      #1;
      chk("valid", {7'h00, rsp.valid}, 8'h01);
   endtask : acc
   task t_stack;
      chk("sp", stack_top_pointer, 8'h07);
      chk("psw", program_status_word, 8'h00);
      acc(DMM_OP_PUSH, 1'b1, 1'b0, 16'h0000, 8'hA5);
      chk("sp", stack_top_pointer, 8'h08);
      acc(DMM_OP_DIRECT, 1'b0, 1'b0, 16'h0008, 8'h00);
      chk("slot", rsp.rdata, 8'hA5);
      acc(DMM_OP_POP, 1'b0, 1'b0, 16'h0000, 8'h00);
      chk("pop", rsp.rdata, 8'hA5);
      $display("done stack");
   endtask : t_stack
   task t_banks;
      for (int b = 0; b < 4; b++) begin
         acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h00D0, 8'(b * 8));
         chk("psw", program_status_word, 8'(b * 8));
         acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'(8 * b + 1), 8'(8'h40 + b));
         acc(DMM_OP_INDIRECT, 1'b1, 1'b1, 16'h0000, 8'(b + 1));
         acc(DMM_OP_DIRECT, 1'b0, 1'b0, 16'(8'h40 + b), 8'h00);
         chk("bank", rsp.rdata, 8'(b + 1));
      end
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h00D0, 8'h00);
      acc(DMM_OP_BIT, 1'b1, 1'b0, 16'h00D4, 8'h01);
      chk("psw_bit", program_status_word, 8'h10);
      acc(DMM_OP_BIT, 1'b0, 1'b0, 16'h00D4, 8'h00);
      chk("psw_bit_rd", {7'h00, rsp.bit_value}, 8'h01);
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h00D0, 8'h00);
      $display("done banks");
   endtask : t_banks
   task t_upper;
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0000, 8'h90);
      acc(DMM_OP_INDIRECT, 1'b1, 1'b0, 16'h0000, 8'h5A);
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0090, 8'h11);
      chk("sfr_we", {7'h00, sfr_we}, 8'h01);
      chk("sfr_addr", sfr_addr, 8'h90);
      chk("sfr_wdata", sfr_wdata, 8'h11);
      acc(DMM_OP_INDIRECT, 1'b0, 1'b0, 16'h0000, 8'h00);
      chk("upper", rsp.rdata, 8'h5A);
      acc(DMM_OP_DIRECT, 1'b0, 1'b0, 16'h0090, 8'h00);
      chk("special", rsp.rdata, 8'h6F);
      chk("sfr_hit", {7'h00, rsp.sfr_hit}, 8'h01);
      $display("done upper");
   endtask : t_upper
   task t_bits;
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0022, 8'h00);
      acc(DMM_OP_BIT, 1'b1, 1'b0, 16'h0013, 8'h01);
      acc(DMM_OP_DIRECT, 1'b0, 1'b0, 16'h0022, 8'h00);
      chk("byte", rsp.rdata, 8'h08);
      acc(DMM_OP_BIT, 1'b0, 1'b0, 16'h0013, 8'h00);
      chk("bit", {7'h00, rsp.bit_value}, 8'h01);
      $display("done bits");
   endtask : t_bits
   task t_on_chip_external_ram;
      acc(DMM_OP_XDATA16, 1'b1, 1'b0, 16'h0305, 8'h77);
      acc(DMM_OP_XDATA16, 1'b0, 1'b0, 16'hA105, 8'h00);
      chk("alias", rsp.rdata, 8'h77);
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0000, 8'h05);
      acc(DMM_OP_XDATA8, 1'b0, 1'b0, 16'h0000, 8'h00);
      chk("mirror", rsp.rdata, 8'h77);
      acc(DMM_OP_XDATA16, 1'b1, 1'b0, 16'hFFFC, 8'h00);
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0000, 8'hFC);
      acc(DMM_OP_XDATA8, 1'b0, 1'b0, 16'h0000, 8'h00);
      chk("uid", rsp.rdata, DMM_UID_VALUE[7:0]);
      chk("no_on_chip_external_ram", rsp_small.rdata, 8'h00);
      $display("done on_chip_external_ram");
   endtask : t_on_chip_external_ram
   task t_small;
      acc(DMM_OP_DIRECT, 1'b1, 1'b0, 16'h0000, 8'hFD);
      acc(DMM_OP_INDIRECT, 1'b1, 1'b0, 16'h0000, 8'h00);
      acc(DMM_OP_INDIRECT, 1'b0, 1'b0, 16'h0000, 8'h00);
      chk("uid_small", rsp_small.rdata, DMM_UID_VALUE[15:8]);
      chk("top_large", rsp.rdata, 8'h00);
      $display("done small");
   endtask : t_small
   task complete_run;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_stack();
      t_banks();
      t_upper();
      t_bits();
      t_on_chip_external_ram();
      t_small();
      complete_run();
   end
endmodule : tb
bind dmm_data_map dmm_data_map_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .sfr_rdata(sfr_rdata),
   .rsp(rsp), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .stack_top_pointer(stack_top_pointer), .program_status_word(program_status_word));
